// ==== core_model.sv ====
// Purpose: Processor core side driving watchdog instruction strobes.
// Assumes: Bench changes op at the falling clock edge.
// Notes:   op 1 service, 2 disable, 3 other, 4 power-down, 5 back-up.
`timescale 1ns/10ps
module core_model (
    // Control from bench
    input  wire logic       run,
    input  wire logic [2:0] op,
    // Strobes to watchdog
    output logic            instrClk,
    output logic            instrExec,
    output logic            serviceSkipInstr,
    output logic            guardDisableInstr,
    output logic            powerDownEntry,
    output logic            ramBackupEntry
);
    // One machine cycle per clock while running
    assign instrClk          = run;
    // Decode one instruction per cycle
    assign instrExec         = op inside {3'h1, 3'h2, 3'h3};
    assign serviceSkipInstr  = op == 3'h1;
    assign guardDisableInstr = op == 3'h2;
    assign powerDownEntry    = op == 3'h4;
    assign ramBackupEntry    = op == 3'h5;
endmodule

// ==== cycle_down_counter.sv ====
// Purpose: 16-bit down counter on instruction clock pulses.
// Assumes: Tick is one cycle wide.
// Notes:   Wraps to all ones after zero.
`timescale 1ns/10ps
`include "wdog_cfg.svh"
module cycle_down_counter
    import wdog_pkg::*;
#(
    parameter int CNT_W = `WDOG_CNT_W
) (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst,
    // Core side
    wdog_cnt_if.counter cnt
);
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // Next count and underflow
    always_comb begin
        count_d = count_q;
        cnt.underflow = 1'b0;
        if (cnt.restart) begin
            count_d = CNT_W'(`WDOG_CNT_INIT);
        end else if (cnt.tick) begin
            count_d = count_q - CNT_W'(1);
            cnt.underflow = (count_q == CNT_W'(`WDOG_CNT_ZERO));
        end
    end

    // Count register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= CNT_W'(`WDOG_CNT_INIT);
        end else begin
            count_q <= count_d;
        end
    end

    a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
        (cnt.tick && !cnt.restart) |=> count_q == $past(count_q) - CNT_W'(1))
        else $error("counter did not step");
    a_restart_load: assert property (@(posedge sys_clk) disable iff (rst)
        cnt.restart |=> count_q == CNT_W'(`WDOG_CNT_INIT))
        else $error("counter not reloaded");
    a_uflow_zero: assert property (@(posedge sys_clk) disable iff (rst)
        cnt.underflow |-> count_q == CNT_W'(0) && cnt.tick)
        else $error("underflow without zero");
endmodule

// ==== instruction_cycle_watchdog.sv ====
// Purpose: Instruction cycle watchdog with service skip and disable.
// Assumes: Instruction strobes are one cycle pulses, one per instruction.
// Notes:   Reset pin output is open drain, low while resetPinOe high.
`timescale 1ns/10ps
`include "wdog_cfg.svh"
module instruction_cycle_watchdog
    import wdog_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Core instruction strobes
    input  wire logic instrClk,
    input  wire logic instrExec,
    input  wire logic serviceSkipInstr,
    input  wire logic guardDisableInstr,
    input  wire logic powerDownEntry,
    input  wire logic ramBackupEntry,
    // Core answers
    output logic      skipNext,
    output logic      firstUnderflowFlag,
    output logic      secondUnderflowFlag,
    output logic      guardEnableFlag,
    // Reset pin
    output logic      resetPinOut,
    output logic      resetPinOe
);
    wdog_cnt_if cntBus ();

    disable_seq_t seq_q;
    disable_seq_t seq_d;
    logic first_q;
    logic first_d;
    logic second_q;
    logic second_d;
    logic enable_q;
    logic enable_d;
    logic skip_q;
    logic skip_d;
    logic wdReset;

    // Counter feed
    assign cntBus.tick    = instrClk;
    assign cntBus.restart = powerDownEntry;

    cycle_down_counter #(
        .CNT_W (`WDOG_CNT_W)
    ) u_counter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cnt     (cntBus)
    );

    // Reset request from a second underflow while enabled
    assign wdReset = cntBus.underflow && first_q && enable_q;

    // Flag and sequencer next state
    always_comb begin
        seq_d    = seq_q;
        first_d  = first_q;
        second_d = second_q;
        enable_d = enable_q;
        skip_d   = 1'b0;
        if (instrExec) begin
            // Disable arms only when the very next instruction serves
            seq_d = guardDisableInstr ? SEQ_ARMED : SEQ_IDLE;
        end
        if (serviceSkipInstr) begin
            skip_d  = first_q;
            first_d = 1'b0;
            if (seq_q == SEQ_ARMED) begin
                enable_d = 1'b0;
            end
        end
        if (cntBus.underflow) begin
            first_d = 1'b1;
        end
        if (wdReset) begin
            second_d = 1'b1;
        end
        if (powerDownEntry) begin
            first_d = 1'b0;
        end
        if (ramBackupEntry) begin
            enable_d = `WDOG_EN_INIT;
        end
    end

    // Flag registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seq_q    <= SEQ_IDLE;
            first_q  <= 1'b0;
            second_q <= 1'b0;
            enable_q <= `WDOG_EN_INIT;
            skip_q   <= 1'b0;
        end else begin
            seq_q    <= seq_d;
            first_q  <= first_d;
            second_q <= second_d;
            enable_q <= enable_d;
            skip_q   <= skip_d;
        end
    end

    // Reset pin pull-down, held until system reset clears it
    assign resetPinOut         = 1'b0;
    assign resetPinOe          = second_q;
    assign skipNext            = skip_q;
    assign firstUnderflowFlag  = first_q;
    assign secondUnderflowFlag = second_q;
    assign guardEnableFlag     = enable_q;

    a_reset_on_second: assert property (@(posedge sys_clk) disable iff (rst)
        (cntBus.underflow && first_q && enable_q) |=> resetPinOe)
        else $error("no reset on second underflow");
    a_no_reset_off: assert property (@(posedge sys_clk) disable iff (rst)
        (!second_q && (!enable_q || !first_q || !cntBus.underflow))
        |=> !second_q)
        else $error("reset while disabled");
    a_first_set: assert property (@(posedge sys_clk) disable iff (rst)
        (cntBus.underflow && !powerDownEntry) |=> first_q)
        else $error("first flag not set");
    a_skip_follow: assert property (@(posedge sys_clk) disable iff (rst)
        serviceSkipInstr |=> skipNext == $past(first_q))
        else $error("skip mismatch");
    a_svc_clears: assert property (@(posedge sys_clk) disable iff (rst)
        (serviceSkipInstr && !cntBus.underflow) |=> !first_q)
        else $error("service left first flag");
    a_pair_disables: assert property (@(posedge sys_clk) disable iff (rst)
        (instrExec && guardDisableInstr) ##1
        (instrExec && serviceSkipInstr && !ramBackupEntry)
        |=> !guardEnableFlag)
        else $error("pair did not disable");
    a_lone_disable: assert property (@(posedge sys_clk) disable iff (rst)
        (guardEnableFlag && (!serviceSkipInstr || seq_q == SEQ_IDLE))
        |=> guardEnableFlag)
        else $error("enable dropped alone");
    a_backup_enable: assert property (@(posedge sys_clk) disable iff (rst)
        ramBackupEntry |=> guardEnableFlag)
        else $error("back-up did not enable");
    a_pd_clears: assert property (@(posedge sys_clk) disable iff (rst)
        powerDownEntry |=> !first_q)
        else $error("power-down kept flag");
    a_pin_hold: assert property (@(posedge sys_clk) disable iff (rst)
        resetPinOe |=> resetPinOe && !resetPinOut)
        else $error("reset pin released");

    c_first_uflow: cover property (@(posedge sys_clk) disable iff (rst)
        cntBus.underflow && !first_q);
    c_wd_reset: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(resetPinOe));
    c_skip: cover property (@(posedge sys_clk) disable iff (rst)
        skipNext);
    c_disabled: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(guardEnableFlag));
endmodule

// ==== tb_instruction_cycle_watchdog.sv ====
// Purpose: Self-checking bench for the instruction cycle watchdog.
// Assumes: Core model strobes, one instruction clock per cycle.
// Notes:   Rows hold op, expected skip and expected enable.
`timescale 1ns/10ps
module tb_instruction_cycle_watchdog;
    logic       sys_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       run     = 1'b1;
    logic [2:0] op      = 3'h0;
    logic       instrClk, instrExec, serviceSkipInstr, guardDisableInstr;
    logic       powerDownEntry, ramBackupEntry, skipNext, resetPinOut;
    logic       firstUnderflowFlag, secondUnderflowFlag, guardEnableFlag;
    logic       resetPinOe;
    int         n_errors  = 0;
    int         tests_run = 0;
    int         n;
    logic [4:0] rows [10] = '{5'h05, 5'h09, 5'h0d, 5'h05, 5'h09, 5'h04,
                              5'h15, 5'h11, 5'h09, 5'h04};

    // Clock source
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    core_model core_u (.run, .op, .instrClk, .instrExec, .serviceSkipInstr,
        .guardDisableInstr, .powerDownEntry, .ramBackupEntry);

    instruction_cycle_watchdog dut_u (.sys_clk, .rst, .instrClk, .instrExec,
        .serviceSkipInstr, .guardDisableInstr, .powerDownEntry,
        .ramBackupEntry, .skipNext, .firstUnderflowFlag,
        .secondUnderflowFlag, .guardEnableFlag, .resetPinOut, .resetPinOe);

    // Compare and count
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %b expected %b", $time, seen,
                exp);
        end
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        // Instruction rows, ending with power-down then disable pair
        for (int i = 0; i < 10; i++) begin
            op = rows[i][4:2];
            @(negedge sys_clk);
            check(skipNext, rows[i][1]);
            check(guardEnableFlag, rows[i][0]);
        end
        op = 3'h0;
        // Underflow counted from the power-down reload
        n = 0;
        while (firstUnderflowFlag !== 1'b1 && n < 70000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 70000) begin
            check(1'b0, 1'b1);
        end else begin
            check(1'(n >= 65533 && n <= 65536), 1'b1);
            check(secondUnderflowFlag, 1'b0);
            check(resetPinOe, 1'b0);
            // Service with flag set while guard is disabled
            op = 3'h1;
            @(negedge sys_clk);
            op = 3'h0;
            check(skipNext, 1'b1);
            check(firstUnderflowFlag, 1'b0);
            @(negedge sys_clk);
            check(skipNext, 1'b0);
            // Mid-run system reset
            rst = 1'b1;
            @(negedge sys_clk);
            check(guardEnableFlag, 1'b1);
            check(secondUnderflowFlag, 1'b0);
            check(resetPinOe, 1'b0);
            check(resetPinOut, 1'b0);
            rst = 1'b0;
            // First edges after the second release
            repeat (2) @(negedge sys_clk);
            check(firstUnderflowFlag, 1'b0);
            check(guardEnableFlag, 1'b1);
            check(skipNext, 1'b0);
        end
        give_verdict();
    end
endmodule

// ==== wdog_cfg.svh ====
// Purpose: Constants for the instruction cycle watchdog.
// Assumes: One instruction clock enable pulse per machine cycle.
// Notes:   Counts are in instruction clocks.
// Behaviour
// - After reset release counter loads all ones, decrements each instruction clock.
// - Count pulse while counter is zero is underflow; sets first flag.
// - Underflow with first flag set sets second flag and issues reset.
// - Watchdog reset turns on reset pin pull-down, driving it low.
// - Without service, second underflow after 131072 counts sets second flag, resets.
// - Reset function active whenever enable flag is one.
// - Disable then service back to back clears enable flag.
// - Enable flag forced to one on reset and RAM back-up entry.
// - Service with first flag set clears it and skips next instruction.
// - Service with first flag clear does not skip.
// - Service skip works even with watchdog reset disabled.
// - Disable instruction alone does not stop the watchdog.
// - Power-down entry reinitialises first flag and counter.
// - One decrement per machine cycle; instruction clock only source.
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH
`define WDOG_CNT_W     16
`define WDOG_CNT_INIT  16'hffff
`define WDOG_CNT_ZERO  16'h0000
`define WDOG_EN_INIT   1'b1
`endif

// ==== wdog_cnt_if.sv ====
// Purpose: Counter to core signals of the watchdog.
// Assumes: Single clock domain.
// Notes:   Counter drives underflow, core drives restart.
`timescale 1ns/10ps
interface wdog_cnt_if;
    logic tick;
    logic restart;
    logic underflow;
    modport counter (input tick, input restart, output underflow);
    modport core    (output tick, output restart, input underflow);
endinterface

// ==== wdog_pkg.sv ====
// Purpose: Types for the instruction cycle watchdog.
// Assumes: Nothing.
// Notes:   Sequencer state for the disable pairing.
package wdog_pkg;
    typedef enum logic {
        SEQ_IDLE,
        SEQ_ARMED
    } disable_seq_t;
endpackage
